// ---- hdl/rmpu_pkg.sv ----
// package: register map, field layout and types of the region protection unit
package rmpu_pkg;

  localparam int unsigned REGION_COUNT = 8;
  localparam int unsigned SUB_COUNT    = 8;

  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_SELECT = 12'h004;
  localparam logic [11:0] OFS_BASE   = 12'h008;
  localparam logic [11:0] OFS_ATTR   = 12'h00c;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam logic [11:0] OFS_FADDR  = 12'h014;
  localparam logic [11:0] OFS_COUNT  = 12'h018;

  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_PRIVDEF_BIT = 1;
  localparam int unsigned CTRL_HFNMI_BIT  = 2;

  localparam int unsigned ATTR_EN_BIT    = 0;
  localparam int unsigned ATTR_SIZE_LSB  = 1;
  localparam int unsigned ATTR_SRD_LSB   = 8;
  localparam int unsigned ATTR_AP_LSB    = 24;
  localparam int unsigned ATTR_XN_BIT    = 28;

  localparam logic [4:0] SIZE_MIN_CODE = 5'h04;
  localparam logic [4:0] SIZE_MAX_CODE = 5'h1f;
  localparam logic [4:0] SIZE_SRD_MIN  = 5'h07;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [2:0]  SEL_RESET  = 3'h0;

  typedef enum logic [2:0] {
    RMPU_AP_NONE       = 3'h0,
    RMPU_AP_PRW_UNONE  = 3'h1,
    RMPU_AP_PRW_URO    = 3'h2,
    RMPU_AP_PRW_URW    = 3'h3,
    RMPU_AP_PRO_UNONE  = 3'h5,
    RMPU_AP_PRO_URO    = 3'h6
  } rmpu_ap_t;

  typedef struct packed {
    logic        xn;
    logic [2:0]  ap;
    logic [7:0]  srd;
    logic [4:0]  size;
    logic        en;
  } rmpu_region_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        write;
    logic        fetch;
    logic        priv;
    logic        in_hf_nmi;
  } rmpu_access_t;

endpackage

// ---- hdl/rmpu_region_match.sv ----
// one region: address match with sub-region holes and permission check
`timescale 1ns/1ps
module rmpu_region_match (
  input  wire logic                  [31:0] base,
  input  wire rmpu_pkg::rmpu_region_t       cfg,
  input  wire rmpu_pkg::rmpu_access_t       acc,
  output logic                              hit,
  output logic                              allow
);

  logic [31:0] mask;
  logic [2:0]  sub_idx;
  logic        ap_ok;

  always_comb begin
    // base alignment is trusted, so a masked compare suffices (see [R03])
    mask    = (cfg.size >= rmpu_pkg::SIZE_MAX_CODE) ? 32'h0000_0000
            : ~((32'h0000_0002 << cfg.size) - 32'h0000_0001); // see [R02]
    sub_idx = 3'h0;
    if (cfg.size >= rmpu_pkg::SIZE_MAX_CODE) begin
      sub_idx = acc.addr[31:29];
    end else if (cfg.size >= rmpu_pkg::SIZE_SRD_MIN) begin
      sub_idx = 3'((acc.addr >> (cfg.size - 5'h02)) & 32'h0000_0007);
    end
    hit = cfg.en && cfg.size >= rmpu_pkg::SIZE_MIN_CODE
          && ((acc.addr & mask) == (base & mask));
    // holes only apply from 256 bytes upward (see [R06] see [R07])
    if (cfg.size >= rmpu_pkg::SIZE_SRD_MIN && cfg.srd[sub_idx]) begin
      hit = 1'b0;
    end
  end

  always_comb begin
    ap_ok = 1'b0;
    case (cfg.ap) // see [R05] see [R08]
      rmpu_pkg::RMPU_AP_PRW_UNONE: ap_ok = acc.priv;
      rmpu_pkg::RMPU_AP_PRW_URO:   ap_ok = acc.priv || !acc.write;
      rmpu_pkg::RMPU_AP_PRW_URW:   ap_ok = 1'b1;
      rmpu_pkg::RMPU_AP_PRO_UNONE: ap_ok = acc.priv && !acc.write;
      rmpu_pkg::RMPU_AP_PRO_URO:   ap_ok = !acc.write;
      default:                     ap_ok = 1'b0;
    endcase
    allow = ap_ok && !(acc.fetch && cfg.xn); // see [R04]
  end

endmodule

// ---- hdl/rmpu_cfg_mem.sv ----
// region configuration store: eight base/attribute words, registered read port
`timescale 1ns/1ps
module rmpu_cfg_mem (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic                   wr_base,
  input  wire logic                   wr_attr,
  input  wire logic [2:0]             wr_idx,
  input  wire logic [31:0]            wr_data,
  input  wire logic [2:0]             rd_idx,
  output logic      [31:0]            rd_base,
  output rmpu_pkg::rmpu_region_t      rd_attr,
  output logic      [8*32-1:0]        all_base,
  output rmpu_pkg::rmpu_region_t [7:0] all_attr
);

  logic [31:0]            base_r [8];
  rmpu_pkg::rmpu_region_t attr_r [8];

  genvar g;
  generate
    for (g = 0; g < rmpu_pkg::REGION_COUNT; g++) begin : g_reg
      // each region kept apart from the others (see [R01])
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          base_r[g] <= 32'h0000_0000;
        end else if (wr_base && wr_idx == 3'(g)) begin
          base_r[g] <= wr_data;
        end
      end
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          attr_r[g] <= '0;
        end else if (wr_attr && wr_idx == 3'(g)) begin
          attr_r[g] <= rmpu_pkg::rmpu_region_t'({wr_data[rmpu_pkg::ATTR_XN_BIT],
                         wr_data[rmpu_pkg::ATTR_AP_LSB +: 3],
                         wr_data[rmpu_pkg::ATTR_SRD_LSB +: 8],
                         wr_data[rmpu_pkg::ATTR_SIZE_LSB +: 5],
                         wr_data[rmpu_pkg::ATTR_EN_BIT]});
        end
      end
      assign all_base[g*32 +: 32] = base_r[g];
      assign all_attr[g]          = attr_r[g];
    end
  endgenerate

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_base <= 32'h0000_0000;
      rd_attr <= '0;
    end else begin
      rd_base <= base_r[rd_idx];
      rd_attr <= attr_r[rd_idx];
    end
  end

endmodule

// ---- hdl/rmpu_top.sv ----
// top: APB register slave and access checker of the region protection unit
`timescale 1ns/1ps

//
// Overview of operation
// [R01] Eight regions, each with own base, size, permissions and enable.
// [R02] Region size is a power of two from 32 bytes to 4 GB.
// [R03] Software aligns each base to its region size; matching relies on it.
// [R04] Fetch from a region marked no-execute is a violation.
// [R05] Read-only, read/write or none, judged separately for privileged and user.
// [R06] Eight equal sub-regions per region, each may be disabled.
// [R07] Sub-region disables act only for regions of 256 bytes or more.
// [R08] Six permission codes supported; others grant nothing.
// [R09] With the unit enabled a permission breach raises a fault.
// [R10] Clearing a region enable keeps base, size and attributes.
// [R11] Attribute readback includes the enable bit.
// [R12] Privileged-default-map option: privileged miss uses default map.
// [R13] Without that option, a miss while enabled faults.
// [R14] Fault-handler option keeps checking in hard-fault and NMI; else bypass.
// [R15] Unit disabled: default map, never a fault.
// [R16] Software should disable a region before rewriting it.
// [R17] Software programs a region or the default-map option before enabling.
// [R18] Highest-numbered matching region decides.
module rmpu_top (
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic      [31:0]           prdata,
  output logic                       pslverr,
  input  wire rmpu_pkg::rmpu_access_t acc,
  output logic                       acc_done,
  output logic                       mem_fault,
  output logic                       default_map_used
);

  typedef enum logic [1:0] {
    RMPU_IDLE  = 2'b00,
    RMPU_FETCH = 2'b01,
    RMPU_REPLY = 2'b11
  } rmpu_bus_t;

  rmpu_bus_t                    bus_r;
  logic [31:0]                  ctrl_r;
  logic [2:0]                   sel_r;
  logic [31:0]                  faddr_r;
  logic                         fsticky_r;
  logic [31:0]                  rd_base;
  rmpu_pkg::rmpu_region_t       rd_attr;
  logic [8*32-1:0]              all_base;
  rmpu_pkg::rmpu_region_t [7:0] all_attr;
  logic [7:0]                   hit_v;
  logic [7:0]                   allow_v;
  logic                         any_hit;
  logic                         win_allow;
  logic                         check_on;
  logic                         fault_nxt;
  logic                         defmap_nxt;
  logic                         wr_take;
  logic                         wr_base;
  logic                         wr_attr;
  logic                         mapped;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = a == rmpu_pkg::OFS_CTRL || a == rmpu_pkg::OFS_SELECT
             || a == rmpu_pkg::OFS_BASE || a == rmpu_pkg::OFS_ATTR
             || a == rmpu_pkg::OFS_STATUS || a == rmpu_pkg::OFS_FADDR
             || a == rmpu_pkg::OFS_COUNT;
  endfunction

  assign mapped  = is_mapped(paddr);
  assign wr_take = psel && penable && pready && pwrite && mapped;
  assign wr_base = wr_take && paddr == rmpu_pkg::OFS_BASE;
  // attribute write replaces only the addressed region (see [R10])
  assign wr_attr = wr_take && paddr == rmpu_pkg::OFS_ATTR;

  rmpu_cfg_mem u_mem (
    .core_clk (core_clk),
    .resetn   (resetn),
    .wr_base  (wr_base),
    .wr_attr  (wr_attr),
    .wr_idx   (sel_r),
    .wr_data  (pwdata),
    .rd_idx   (sel_r),
    .rd_base  (rd_base),
    .rd_attr  (rd_attr),
    .all_base (all_base),
    .all_attr (all_attr)
  );

  genvar g;
  generate
    for (g = 0; g < rmpu_pkg::REGION_COUNT; g++) begin : g_chk
      rmpu_region_match u_match (
        .base  (all_base[g*32 +: 32]),
        .cfg   (all_attr[g]),
        .acc   (acc),
        .hit   (hit_v[g]),
        .allow (allow_v[g])
      );
    end
  endgenerate

  // higher index overrides lower (see [R18])
  always_comb begin
    any_hit   = 1'b0;
    win_allow = 1'b0;
    for (int i = 0; i < rmpu_pkg::REGION_COUNT; i++) begin
      if (hit_v[i]) begin
        any_hit   = 1'b1;
        win_allow = allow_v[i];
      end
    end
  end

  always_comb begin
    // see [R15] see [R14]
    check_on = ctrl_r[rmpu_pkg::CTRL_ENABLE_BIT]
               && (!acc.in_hf_nmi || ctrl_r[rmpu_pkg::CTRL_HFNMI_BIT]);
    fault_nxt  = 1'b0;
    defmap_nxt = 1'b0;
    if (acc.valid) begin
      if (!check_on) begin
        defmap_nxt = 1'b1;
      end else if (any_hit) begin
        fault_nxt = !win_allow; // see [R09]
      end else if (acc.priv && ctrl_r[rmpu_pkg::CTRL_PRIVDEF_BIT]) begin
        defmap_nxt = 1'b1; // see [R12]
      end else begin
        fault_nxt = 1'b1; // see [R13]
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc_done         <= 1'b0;
      mem_fault        <= 1'b0;
      default_map_used <= 1'b0;
    end else begin
      acc_done         <= acc.valid;
      mem_fault        <= fault_nxt;
      default_map_used <= defmap_nxt;
    end
  end

  // sticky fault capture; a new fault wins over a software clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fsticky_r <= 1'b0;
      faddr_r   <= 32'h0000_0000;
    end else if (fault_nxt) begin
      fsticky_r <= 1'b1;
      faddr_r   <= acc.addr;
    end else if (wr_take && paddr == rmpu_pkg::OFS_STATUS && pwdata[0]) begin
      fsticky_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= rmpu_pkg::CTRL_RESET;
    end else if (wr_take && paddr == rmpu_pkg::OFS_CTRL) begin
      ctrl_r <= {29'h0, pwdata[2:0]};
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sel_r <= rmpu_pkg::SEL_RESET;
    end else if (wr_take && paddr == rmpu_pkg::OFS_SELECT) begin
      sel_r <= pwdata[2:0];
    end
  end

  // one wait state so the memory's registered read port settles
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bus_r   <= RMPU_IDLE;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      case (bus_r)
        RMPU_IDLE: begin
          pready  <= 1'b0;
          pslverr <= 1'b0;
          if (psel && !penable) begin
            bus_r <= RMPU_FETCH;
          end
        end
        RMPU_FETCH: begin
          bus_r   <= RMPU_REPLY;
          pready  <= 1'b1;
          pslverr <= !mapped;
          prdata  <= 32'h0000_0000;
          if (!pwrite) begin
            case (paddr)
              rmpu_pkg::OFS_CTRL:   prdata <= ctrl_r;
              rmpu_pkg::OFS_SELECT: prdata <= {29'h0, sel_r};
              rmpu_pkg::OFS_BASE:   prdata <= rd_base;
              // enable travels with the attributes (see [R11])
              rmpu_pkg::OFS_ATTR: begin
                prdata[rmpu_pkg::ATTR_XN_BIT]        <= rd_attr.xn;
                prdata[rmpu_pkg::ATTR_AP_LSB +: 3]   <= rd_attr.ap;
                prdata[rmpu_pkg::ATTR_SRD_LSB +: 8]  <= rd_attr.srd;
                prdata[rmpu_pkg::ATTR_SIZE_LSB +: 5] <= rd_attr.size;
                prdata[rmpu_pkg::ATTR_EN_BIT]        <= rd_attr.en;
              end
              rmpu_pkg::OFS_STATUS: prdata <= {31'h0, fsticky_r};
              rmpu_pkg::OFS_FADDR:  prdata <= faddr_r;
              rmpu_pkg::OFS_COUNT:  prdata <= 32'(rmpu_pkg::REGION_COUNT);
              default:              prdata <= 32'h0000_0000;
            endcase
          end
        end
        RMPU_REPLY: begin
          bus_r   <= RMPU_IDLE;
          pready  <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          bus_r  <= RMPU_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ---- dv/rmpu_core_model.sv ----
// processor core model: presents one memory access per request
`timescale 1ns/1ps
module rmpu_core_model (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire rmpu_pkg::rmpu_access_t req,
  output rmpu_pkg::rmpu_access_t      acc
);
  // an idle bus inverts its previous fields every cycle, never a held value
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc <= '0;
    end else if (req.valid) begin
      acc <= req;
    end else begin
      acc <= {1'b0, ~acc[35:0]};
    end
  end
endmodule

// ---- dv/rmpu_asserts.sv ----
// checker: concurrent properties on the ports of the protection unit top
`timescale 1ns/1ps
module rmpu_asserts (
  input wire logic                   core_clk,
  input wire logic                   resetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic                   pready,
  input wire logic [31:0]            prdata,
  input wire logic                   pslverr,
  input wire rmpu_pkg::rmpu_access_t acc,
  input wire logic                   acc_done,
  input wire logic                   mem_fault,
  input wire logic                   default_map_used
);
  logic en_r;
  logic pd_r;
  logic hf_r;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // shadow of the global options, taken at the edge a write lands
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      en_r <= 1'b0;
      pd_r <= 1'b0;
      hf_r <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == rmpu_pkg::OFS_CTRL) begin
      en_r <= pwdata[0];
      pd_r <= pwdata[1];
      hf_r <= pwdata[2];
    end
  end
  a_access_done: assert property (acc.valid |=> acc_done)
    else $error("acc_done missing after access");
  a_no_spurious: assert property (
    !acc.valid |=> !acc_done && !mem_fault && !default_map_used)
    else $error("outcome without access");
  a_outcome_excl: assert property (mem_fault |-> acc_done && !default_map_used)
    else $error("fault and default map together");
  a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr without pready or with data");
  a_unit_off: assert property (
    !en_r && acc.valid |=> default_map_used && !mem_fault)
    else $error("disabled unit did not use default map");
  a_hf_bypass: assert property (
    en_r && !hf_r && acc.valid && acc.in_hf_nmi |=> default_map_used && !mem_fault)
    else $error("fault handler access was checked");
  // default map only where the unit is off, bypassed or the option allows it
  a_dmap_gated: assert property (
    acc.valid && en_r && (hf_r || !acc.in_hf_nmi) && !(acc.priv && pd_r)
    |=> !default_map_used)
    else $error("default map used while checking was due");
  c_fault: cover property (mem_fault);
  c_dmap: cover property (default_map_used && en_r);
  c_slverr: cover property (pslverr);
  c_hf_check: cover property (en_r && hf_r && acc.valid && acc.in_hf_nmi ##1 mem_fault);
endmodule

bind rmpu_top rmpu_asserts rmpu_asserts_i (.core_clk(core_clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .acc(acc), .acc_done(acc_done),
  .mem_fault(mem_fault), .default_map_used(default_map_used));

// ---- dv/tb.sv ----
// testbench: scenarios for the region protection unit
`timescale 1ns/1ps
module tb;
  logic                   core_clk;
  logic                   resetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [11:0]            paddr;
  logic [31:0]            pwdata;
  logic                   pready;
  logic [31:0]            prdata;
  logic                   pslverr;
  rmpu_pkg::rmpu_access_t req;
  rmpu_pkg::rmpu_access_t acc;
  logic                   acc_done;
  logic                   mem_fault;
  logic                   default_map_used;
  logic [31:0]            rd;
  logic                   err;
  int                     failures;
  int                     checked;

  rmpu_top rmpu_top_i (.core_clk(core_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .acc(acc), .acc_done(acc_done),
    .mem_fault(mem_fault), .default_map_used(default_map_used));
  rmpu_core_model rmpu_core_model_i (.core_clk(core_clk), .resetn(resetn), .req(req),
    .acc(acc));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no cycle limit here: the watchdog ends a hung transfer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] attr(logic xn, logic [2:0] ap, logic [7:0] srd,
                                       logic [4:0] sz);
    return {3'h0, xn, 1'h0, ap, 8'h0, srd, 2'h0, sz, 1'b1};
  endfunction

  function automatic logic allow(logic [2:0] ap, logic p, logic w);
    case (ap)
      3'h1: return p;
      3'h2: return p | !w;
      3'h3: return 1'b1;
      3'h5: return p & !w;
      3'h6: return !w;
      default: return 1'b0;
    endcase
  endfunction

  task automatic region(input logic [2:0] i, input logic [31:0] b, input logic [31:0] at);
    apb(1'b1, rmpu_pkg::OFS_SELECT, {29'h0, i});
    apb(1'b1, rmpu_pkg::OFS_ATTR, 32'h0);
    apb(1'b1, rmpu_pkg::OFS_BASE, b);
    apb(1'b1, rmpu_pkg::OFS_ATTR, at);
  endtask

  // kind: write, fetch, priv, in_hf_nmi; want: 0 allowed, 1 fault, 2 default map
  task automatic access(input logic [31:0] a, input logic [3:0] k, input logic [1:0] want);
    @(posedge core_clk);
    req <= {1'b1, a, k};
    @(posedge core_clk);
    req.valid <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("access outcome", {30'h1, want == 2'h2, want == 2'h1},
        {29'h0, acc_done, default_map_used, mem_fault});
  endtask

  task automatic t_regs;
    apb(1'b0, rmpu_pkg::OFS_COUNT, 32'h0);
    chk("region count", 32'h8, rd);
    apb(1'b0, rmpu_pkg::OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    access(32'h0000_9000, 4'h2, 2'h2);
    access(32'h0000_9000, 4'h8, 2'h2);
  endtask

  task automatic t_miss;
    // a region exists, left disabled, before the unit is switched on
    region(3'h7, 32'h4000_0000, attr(1'b0, 3'h3, 8'h0, 5'h0b) & 32'hffff_fffe);
    apb(1'b1, rmpu_pkg::OFS_CTRL, 32'h1);
    access(32'h0000_9000, 4'h0, 2'h1);
    apb(1'b0, rmpu_pkg::OFS_FADDR, 32'h0);
    chk("fault addr", 32'h0000_9000, rd);
    apb(1'b0, rmpu_pkg::OFS_STATUS, 32'h0);
    chk("fault flag", 32'h1, rd);
    apb(1'b1, rmpu_pkg::OFS_STATUS, 32'h1);
    apb(1'b0, rmpu_pkg::OFS_STATUS, 32'h0);
    chk("fault flag clear", 32'h0, rd);
    apb(1'b1, rmpu_pkg::OFS_CTRL, 32'h3);
    access(32'h0000_9000, 4'h2, 2'h2);
    access(32'h0000_9000, 4'h0, 2'h1);
    apb(1'b1, rmpu_pkg::OFS_CTRL, 32'h1);
  endtask

  task automatic t_ap;
    for (int ap = 0; ap < 8; ap++) begin
      region(3'h0, 32'h0000_1000, attr(1'b0, ap[2:0], 8'h0, 5'h0b));
      for (int m = 0; m < 4; m++) begin
        access(32'h0000_1234, {m[0], 1'b0, m[1], 1'b0},
               {1'b0, !allow(ap[2:0], m[1], m[0])});
      end
    end
  endtask

  task automatic t_xn_sub_size;
    region(3'h0, 32'h0000_1000, attr(1'b1, 3'h3, 8'h0, 5'h0b));
    access(32'h0000_1100, 4'h6, 2'h1);
    access(32'h0000_1100, 4'h2, 2'h0);
    region(3'h0, 32'h0000_1000, attr(1'b0, 3'h3, 8'h04, 5'h0b));
    access(32'h0000_1600, 4'h6, 2'h0);
    access(32'h0000_1400, 4'h2, 2'h1);
    region(3'h0, 32'h0000_0100, attr(1'b0, 3'h3, 8'hff, 5'h06));
    access(32'h0000_0140, 4'h2, 2'h0);
    region(3'h0, 32'h0000_0100, attr(1'b0, 3'h3, 8'h01, 5'h07));
    access(32'h0000_0100, 4'h2, 2'h1);
    access(32'h0000_0120, 4'h2, 2'h0);
    region(3'h0, 32'h0000_0020, attr(1'b0, 3'h3, 8'h0, 5'h04));
    access(32'h0000_003f, 4'h2, 2'h0);
    access(32'h0000_0040, 4'h2, 2'h1);
    region(3'h0, 32'h0000_0000, attr(1'b0, 3'h3, 8'h0, 5'h1f));
    access(32'hffff_fff0, 4'h2, 2'h0);
  endtask

  task automatic t_overlap_hf;
    logic [31:0] off;
    off = attr(1'b0, 3'h0, 8'h0, 5'h0b) & 32'hffff_fffe;
    region(3'h0, 32'h0000_1000, attr(1'b0, 3'h3, 8'h0, 5'h0b));
    region(3'h1, 32'h0000_1000, attr(1'b0, 3'h0, 8'h0, 5'h0b));
    access(32'h0000_1010, 4'h2, 2'h1);
    apb(1'b1, rmpu_pkg::OFS_ATTR, off);
    access(32'h0000_1010, 4'h2, 2'h0);
    apb(1'b0, rmpu_pkg::OFS_SELECT, 32'h0);
    chk("select readback", 32'h1, rd);
    apb(1'b0, rmpu_pkg::OFS_BASE, 32'h0);
    chk("base kept", 32'h0000_1000, rd);
    apb(1'b0, rmpu_pkg::OFS_ATTR, 32'h0);
    chk("attr readback", off, rd);
    apb(1'b1, rmpu_pkg::OFS_ATTR, off | 32'h1);
    access(32'h0000_1010, 4'h2, 2'h1);
    access(32'h0000_1010, 4'h3, 2'h2);
    apb(1'b1, rmpu_pkg::OFS_CTRL, 32'h5);
    access(32'h0000_1010, 4'h3, 2'h1);
    apb(1'b1, rmpu_pkg::OFS_CTRL, 32'h0);
    access(32'h0000_1010, 4'h3, 2'h2);
  endtask

  task automatic summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    req = '0;
    failures = 0;
    checked = 0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs;
    t_miss;
    t_ap;
    t_xn_sub_size;
    t_overlap_hf;
    summarize;
  end

  // whole run is well under a thousand cycles
  initial begin
    #100000;
    failures++;
    summarize;
  end
endmodule
